// ### verilog/seq_defines.vh
// Constants shared by the sequencer core, its assertions and its bench.
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH
`define SEQ_PC_W 11
`define SEQ_PAGE_W 4
`define SEQ_SP_RESET 2'h3
`define SEQ_PC_RESET 11'h000
`define SEQ_CALL_PAGE 4'h2
`define SEQ_TICK_LAST 2'h3
`define SEQ_RAM_WORDS 64
`define SEQ_ST_FETCH 1'b0
`define SEQ_ST_TABLE 1'b1
`define SEQ_CLS_MISC 2'h0
`define SEQ_CLS_BIT 2'h1
`define SEQ_CLS_IMM 2'h2
`define SEQ_CLS_TAB 2'h3
`define SEQ_SUB_0 2'h0
`define SEQ_SUB_1 2'h1
`define SEQ_SUB_2 2'h2
`define SEQ_SUB_3 2'h3
`define SEQ_M_ADD_MEM 6'h01
`define SEQ_M_ADD_CARRY 6'h02
`define SEQ_M_ROTATE 6'h03
`define SEQ_M_SET_CARRY 6'h04
`define SEQ_M_CLR_CARRY 6'h05
`define SEQ_M_SET_TOPBIT 6'h06
`define SEQ_M_RETURN 6'h07
`define SEQ_M_RETURN_SKIP 6'h08
`define SEQ_M_E_FROM_BA 6'h09
`define SEQ_M_BA_FROM_E 6'h0A
`define SEQ_M_D_FROM_A 6'h0B
`define SEQ_M_A_FROM_MEM 6'h0C
`define SEQ_M_MEM_FROM_A 6'h0D
`define SEQ_M_CMP_SKIP 6'h0E
`define SEQ_M_B_FROM_A 6'h0F
`define SEQ_M_A_FROM_B 6'h10
`define SEQ_M_CARRY_SKIP 6'h11
`define SEQ_ADDR_CTRL 8'h00
`define SEQ_ADDR_STATUS 8'h04
`define SEQ_ADDR_REGS 8'h08
`define SEQ_CTRL_RUN 0
`define SEQ_CTRL_BACKUP 1
`define SEQ_RESP_OKAY 2'h0
`define SEQ_RESP_SLVERR 2'h2
`endif

// ### verilog/seq_stack_slot.v
// One return-address slot of the call stack.
`timescale 1ns/1ps
`default_nettype none
module seq_stack_slot #(
    parameter WIDTH = 11
) (
    input wire aclk,
    input wire aresetn,
    input wire load,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            dout <= {WIDTH{1'b0}};
        end else if (load) begin
            dout <= din;
        end
    end
endmodule
`default_nettype wire

// ### verilog/seq_core.v
// Register, flag and program sequencing core of a 4-bit controller.
// Functional notes
// RQ1: Arithmetic unit adds, compares and manipulates bits of 4-bit values.
// RQ2: Add-with-carry sets carry flag on carry out of the nibble sum.
// RQ3: Add-immediate and add-memory leave the carry flag untouched.
// RQ4: Rotate right through carry moves accumulator bit 0 into carry.
// RQ5: Carry-set forces carry to one; carry-clear forces it to zero.
// RQ6: Register E loads from and moves to B/A, B high nibble.
// RQ7: D with accumulator forms 7-bit in-page address for table and jumps.
// RQ8: Table fetch copies ROM bit 8 into carry only when enable set.
// RQ9: Top-bit enable clears at reset or back-up return; set only.
// RQ10: Four stack slots save PC on calls and table fetch.
// RQ11: Table fetch occupies one stack level while it runs.
// RQ12: Two-bit stack pointer increments on push and wraps around.
// RQ13: Stack pointer holds 3 after reset; first call uses slot 0.
// RQ14: Skip nullifies next instruction; skipped table fetch takes one cycle.
// RQ15: PC advances by instruction length or loads jump targets.
// RQ16: PC has page field and 7-bit offset; offset 127 rolls to next page.
// RQ17: RAM pointer is X file plus Y digit; Y selects port bit.
// RQ18: Program words are 9 bits in 128-word pages.
// RQ19: One-word call reaches routines starting in page 2 from anywhere.
// RQ20: Table fetch reads any program memory word as data.
// RQ21: Data memory is 4-bit words with bit set, clear and test-skip.
// RQ22: Skip flag set by true condition, consumed by next instruction slot.
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.vh"
module seq_core (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [10:0] rom_addr,
    input wire [8:0] rom_data,
    output reg [7:0] port_d_out,
    input wire [7:0] port_d_in,
    input wire backup_return
);
    reg run;
    reg backup_req;
    reg [1:0] tick_cnt;
    reg state;
    reg [3:0] acc;
    reg [3:0] reg_b;
    reg [2:0] reg_d;
    reg [7:0] reg_e;
    reg carry_flag;
    reg rom_top_bit_ref_enable;
    reg skip;
    reg [1:0] reg_x;
    reg [3:0] reg_y;
    reg [1:0] stack_level_pointer;
    reg [3:0] ram [0:`SEQ_RAM_WORDS-1];
    reg [3:0] next_acc;
    reg [3:0] next_b;
    reg [2:0] next_d;
    reg [7:0] next_e;
    reg next_carry;
    reg next_urs;
    reg next_skip;
    reg [1:0] next_x;
    reg [3:0] next_y;
    reg [10:0] next_pc;
    reg [1:0] next_sp;
    reg next_state;
    reg [7:0] next_port;
    reg push;
    reg ram_we;
    reg [3:0] ram_wdata;
    wire [`SEQ_PC_W*4-1:0] slot_q;
    wire [10:0] pc_inc;
    wire [10:0] ret_addr;
    wire [5:0] ram_pointer;
    wire [3:0] mem;
    wire [4:0] sum_mem;
    wire [4:0] sum_carry;
    wire [4:0] sum_imm;
    wire [6:0] in_page_offset;
    wire [3:0] page_select_bits;
    wire [1:0] cls;
    wire [1:0] sub;
    wire [3:0] imm;
    wire [5:0] misc;
    wire tick;
    wire restart;

    // Instruction clock: one execute slot every fourth system clock.
    assign tick = run && (tick_cnt == `SEQ_TICK_LAST);
    assign restart = backup_return || backup_req;
    assign pc_inc = rom_addr + 11'h001; // RQ16
    assign page_select_bits = rom_addr[10:7];
    assign in_page_offset = {reg_d, acc}; // RQ7
    assign ret_addr = slot_q[stack_level_pointer*`SEQ_PC_W +: `SEQ_PC_W];
    assign ram_pointer = {reg_x, reg_y}; // RQ17
    assign mem = ram[ram_pointer];
    assign sum_mem = {1'b0, acc} + {1'b0, mem}; // RQ1
    assign sum_carry = sum_mem + {4'h0, carry_flag};
    assign sum_imm = {1'b0, acc} + {1'b0, imm};
    assign cls = rom_data[7:6];
    assign sub = rom_data[5:4];
    assign imm = rom_data[3:0];
    assign misc = rom_data[5:0];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_slot
            seq_stack_slot #(.WIDTH(`SEQ_PC_W)) u_slot (
                .aclk(aclk),
                .aresetn(aresetn),
                .load(push && (next_sp == gi)), // RQ10
                .din(pc_inc),
                .dout(slot_q[gi*`SEQ_PC_W +: `SEQ_PC_W])
            );
        end
    endgenerate

    always @* begin
        next_acc = acc;
        next_b = reg_b;
        next_d = reg_d;
        next_e = reg_e;
        next_carry = carry_flag;
        next_urs = rom_top_bit_ref_enable;
        next_skip = 1'b0;
        next_x = reg_x;
        next_y = reg_y;
        next_pc = pc_inc; // RQ15
        next_sp = stack_level_pointer;
        next_state = `SEQ_ST_FETCH;
        next_port = port_d_out;
        push = 1'b0;
        ram_we = 1'b0;
        ram_wdata = mem;
        if (state == `SEQ_ST_TABLE) begin
            // Second slot of a table fetch: the word at the table address is data.
            next_acc = rom_data[3:0]; // RQ20
            next_b = rom_data[7:4];
            if (rom_top_bit_ref_enable) begin
                next_carry = rom_data[8]; // RQ8
            end
            next_pc = ret_addr; // RQ11
            next_sp = stack_level_pointer - 2'h1;
        end else if (skip) begin
            // A skipped word costs one slot and only advances the counter.
            next_pc = pc_inc; // RQ14
        end else if (rom_data[8]) begin
            if (rom_data[7]) begin
                next_pc = {`SEQ_CALL_PAGE, rom_data[6:0]}; // RQ19
                next_sp = stack_level_pointer + 2'h1; // RQ12
                push = 1'b1;
            end else begin
                next_pc = {page_select_bits, rom_data[6:0]};
            end
        end else begin
            case (cls)
                `SEQ_CLS_TAB: begin
                    if (sub == `SEQ_SUB_0) begin
                        next_pc = {imm, in_page_offset}; // RQ7
                        next_sp = stack_level_pointer + 2'h1; // RQ11
                        push = 1'b1;
                        next_state = `SEQ_ST_TABLE;
                    end else if (sub == `SEQ_SUB_1) begin
                        next_pc = {imm, in_page_offset}; // RQ15
                    end else if (sub == `SEQ_SUB_2) begin
                        next_pc = {imm, in_page_offset};
                        next_sp = stack_level_pointer + 2'h1; // RQ12
                        push = 1'b1;
                    end
                end
                `SEQ_CLS_IMM: begin
                    case (sub)
                        `SEQ_SUB_0: begin
                            next_acc = sum_imm[3:0]; // RQ3
                        end
                        `SEQ_SUB_1: begin
                            next_acc = imm;
                        end
                        `SEQ_SUB_2: begin
                            next_y = imm;
                        end
                        default: begin
                            next_x = imm[1:0];
                        end
                    endcase
                end
                `SEQ_CLS_BIT: begin
                    case (sub)
                        `SEQ_SUB_0: begin
                            ram_we = 1'b1;
                            ram_wdata = mem | (4'h1 << rom_data[1:0]); // RQ21
                        end
                        `SEQ_SUB_1: begin
                            ram_we = 1'b1;
                            ram_wdata = mem & ~(4'h1 << rom_data[1:0]); // RQ21
                        end
                        `SEQ_SUB_2: begin
                            next_skip = ~mem[rom_data[1:0]]; // RQ22
                        end
                        default: begin
                            if (rom_data[1:0] == `SEQ_SUB_0) begin
                                next_port[reg_y[2:0]] = 1'b1; // RQ17
                            end else if (rom_data[1:0] == `SEQ_SUB_1) begin
                                next_port[reg_y[2:0]] = 1'b0;
                            end else if (rom_data[1:0] == `SEQ_SUB_2) begin
                                next_skip = ~port_d_in[reg_y[2:0]]; // RQ17
                            end
                        end
                    endcase
                end
                default: begin
                    case (misc)
                        `SEQ_M_ADD_MEM: begin
                            next_acc = sum_mem[3:0]; // RQ3
                        end
                        `SEQ_M_ADD_CARRY: begin
                            next_acc = sum_carry[3:0];
                            next_carry = sum_carry[4]; // RQ2
                        end
                        `SEQ_M_ROTATE: begin
                            next_acc = {carry_flag, acc[3:1]};
                            next_carry = acc[0]; // RQ4
                        end
                        `SEQ_M_SET_CARRY: begin
                            next_carry = 1'b1; // RQ5
                        end
                        `SEQ_M_CLR_CARRY: begin
                            next_carry = 1'b0; // RQ5
                        end
                        `SEQ_M_SET_TOPBIT: begin
                            next_urs = 1'b1; // RQ9
                        end
                        `SEQ_M_RETURN: begin
                            next_pc = ret_addr; // RQ15
                            next_sp = stack_level_pointer - 2'h1;
                        end
                        `SEQ_M_RETURN_SKIP: begin
                            next_pc = ret_addr;
                            next_sp = stack_level_pointer - 2'h1;
                            next_skip = 1'b1; // RQ22
                        end
                        `SEQ_M_E_FROM_BA: begin
                            next_e = {reg_b, acc}; // RQ6
                        end
                        `SEQ_M_BA_FROM_E: begin
                            next_b = reg_e[7:4]; // RQ6
                            next_acc = reg_e[3:0];
                        end
                        `SEQ_M_D_FROM_A: begin
                            next_d = acc[2:0];
                        end
                        `SEQ_M_A_FROM_MEM: begin
                            next_acc = mem;
                        end
                        `SEQ_M_MEM_FROM_A: begin
                            ram_we = 1'b1;
                            ram_wdata = acc;
                        end
                        `SEQ_M_CMP_SKIP: begin
                            next_skip = (acc == mem); // RQ1
                        end
                        `SEQ_M_B_FROM_A: begin
                            next_b = acc;
                        end
                        `SEQ_M_A_FROM_B: begin
                            next_acc = reg_b;
                        end
                        `SEQ_M_CARRY_SKIP: begin
                            next_skip = carry_flag;
                        end
                        default: begin
                            next_acc = acc;
                        end
                    endcase
                end
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= 2'h0;
        end else if (run) begin
            tick_cnt <= tick_cnt + 2'h1;
        end
    end

    // The back-up return acts like a reset of the sequencer only;
    // the RAM keeps its contents because that is the point of back-up.
    always @(posedge aclk) begin
        if (!aresetn || restart) begin
            state <= `SEQ_ST_FETCH;
            acc <= 4'h0;
            reg_b <= 4'h0;
            reg_d <= 3'h0;
            reg_e <= 8'h00;
            carry_flag <= 1'b0;
            rom_top_bit_ref_enable <= 1'b0; // RQ9
            skip <= 1'b0;
            reg_x <= 2'h0;
            reg_y <= 4'h0;
            rom_addr <= `SEQ_PC_RESET;
            stack_level_pointer <= `SEQ_SP_RESET; // RQ13
            port_d_out <= 8'h00;
        end else if (tick) begin
            state <= next_state;
            acc <= next_acc;
            reg_b <= next_b;
            reg_d <= next_d;
            reg_e <= next_e;
            carry_flag <= next_carry;
            rom_top_bit_ref_enable <= next_urs;
            skip <= next_skip; // RQ22
            reg_x <= next_x;
            reg_y <= next_y;
            rom_addr <= next_pc; // RQ18
            stack_level_pointer <= next_sp; // RQ12
            port_d_out <= next_port;
        end
    end

    always @(posedge aclk) begin
        if (tick && ram_we && !restart) begin
            ram[ram_pointer] <= ram_wdata;
        end
    end

    reg aw_hold;
    reg w_hold;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire aw_take;
    wire w_take;
    wire do_write;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;

    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = (aw_hold || aw_take) && (w_hold || w_take);
    assign wr_addr = aw_hold ? aw_addr_q : s_axi_awaddr;
    assign wr_data = w_hold ? w_data_q : s_axi_wdata;
    assign wr_strb = w_hold ? w_strb_q : s_axi_wstrb;

    // Address and data may arrive in either order; the response waits for both.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SEQ_RESP_OKAY;
            run <= 1'b0;
            backup_req <= 1'b0;
        end else begin
            backup_req <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr[7:2] == `SEQ_ADDR_CTRL >> 2) begin
                    s_axi_bresp <= `SEQ_RESP_OKAY;
                    if (wr_strb[0]) begin
                        run <= wr_data[`SEQ_CTRL_RUN];
                        backup_req <= wr_data[`SEQ_CTRL_BACKUP];
                    end
                end else if (wr_addr[7:2] == `SEQ_ADDR_STATUS >> 2) begin
                    s_axi_bresp <= `SEQ_RESP_OKAY;
                end else if (wr_addr[7:2] == `SEQ_ADDR_REGS >> 2) begin
                    s_axi_bresp <= `SEQ_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SEQ_RESP_SLVERR;
                end
            end else begin
                if (aw_take) begin
                    aw_hold <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_hold <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SEQ_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SEQ_RESP_OKAY;
            if (s_axi_araddr[7:2] == `SEQ_ADDR_CTRL >> 2) begin
                s_axi_rdata <= {31'h00000000, run};
            end else if (s_axi_araddr[7:2] == `SEQ_ADDR_STATUS >> 2) begin
                s_axi_rdata <= {11'h000, run, state, skip, rom_top_bit_ref_enable,
                                carry_flag, 2'h0, stack_level_pointer, 1'b0, rom_addr};
            end else if (s_axi_araddr[7:2] == `SEQ_ADDR_REGS >> 2) begin
                s_axi_rdata <= {reg_y, 2'h0, reg_x, reg_e, 5'h00, reg_d, reg_b, acc};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `SEQ_RESP_SLVERR;
            end
        end
    end
endmodule
`default_nettype wire

// ### verification/seq_core_asserts.sv
// Port-level checks for the sequencer core.
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.vh"
module seq_core_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [10:0] rom_addr,
    input wire logic [8:0] rom_data,
    input wire logic backup_return
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write response missing");
    a_write_map: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
        s_axi_bresp == (($past(s_axi_awaddr) inside {8'h00, 8'h04, 8'h08}) ? `SEQ_RESP_OKAY : `SEQ_RESP_SLVERR))
        else $error("write response code wrong");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
        s_axi_rresp == (($past(s_axi_araddr) inside {8'h00, 8'h04, 8'h08}) ? `SEQ_RESP_OKAY : `SEQ_RESP_SLVERR))
        else $error("read response wrong");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `SEQ_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    a_tick_spacing: assert property ($changed(rom_addr) && !$past(backup_return) |=>
        ($stable(rom_addr) || $past(backup_return)) [*3])
        else $error("instruction slots too close");
    a_page_roll: assert property ($changed(rom_addr) && $past(rom_addr[6:0]) == 7'h7F && rom_addr[6:0] == 7'h0 &&
        ($past(rom_data[8:6]) inside {3'b010, 3'b001}) |-> rom_addr[10:7] == $past(rom_addr[10:7]) + 4'h1)
        else $error("page field did not advance");
endmodule
bind seq_core seq_core_asserts chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rom_addr(rom_addr), .rom_data(rom_data), .backup_return(backup_return)
);
`default_nettype wire

// ### verification/seq_rom_model.sv
// Program memory model at the far side of the core.
`timescale 1ns/1ps
`default_nettype none
module seq_rom_model (
    input wire logic [10:0] rom_addr,
    output logic [8:0] rom_data
);
    // Sixteen pages of 128 nine-bit words; the bench fills the contents.
    logic [8:0] mem [0:2047];
    // Reads are combinational because the core samples the word in the cycle it drives the address.
    assign rom_data = mem[rom_addr];
endmodule
`default_nettype wire

// ### verification/seq_core_tb.sv
// Self-checking bench for the sequencer core with its program memory.
`timescale 1ns/1ps
`default_nettype none
`include "seq_defines.vh"
module seq_core_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, port_d_in = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, backup_return = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [1:0] r;
    logic [10:0] rom_addr;
    logic [8:0] rom_data;
    logic [7:0] port_d_out;
    int miscompares = 0;
    int checks_done = 0;
    logic [8:0] prog [0:23] = '{9'h09F, 9'h004, 9'h081, 9'h011, 9'h0B1, 9'h005, 9'h099, 9'h00D, 9'h098, 9'h002,
        9'h00F, 9'h096, 9'h009, 9'h003, 9'h180, 9'h00B, 9'h006, 9'h005, 9'h0C5, 9'h0A5, 9'h070, 9'h072, 9'h090, 9'h17E};
    seq_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rom_addr(rom_addr),
        .rom_data(rom_data), .port_d_out(port_d_out), .port_d_in(port_d_in), .backup_return(backup_return));
    seq_rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));
    initial begin
        forever #5 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Only the watchdog ends a wait; a stalled response must not pass as stale data.
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_reset_state;
        axi_rd(`SEQ_ADDR_STATUS, d, r);
        check(d, 32'h00003000);
        axi_rd(`SEQ_ADDR_CTRL, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, `SEQ_RESP_OKAY});
    endtask
    task automatic t_program;
        int n;
        axi_wr(`SEQ_ADDR_CTRL, 32'h1, r);
        for (n = 0; n < 100 && d[10:0] !== 11'h081; n++) axi_rd(`SEQ_ADDR_STATUS, d, r);
        axi_rd(`SEQ_ADDR_STATUS, d, r);
        check(d, 32'h00133081);
        axi_rd(`SEQ_ADDR_REGS, d, r);
        check(d, 32'h501603A6);
        check({24'h0, port_d_out}, 32'h20);
    endtask
    task automatic t_map;
        axi_rd(8'h0C, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, `SEQ_RESP_SLVERR});
        axi_wr(8'h0C, 32'h1, r);
        check({30'h0, r}, {30'h0, `SEQ_RESP_SLVERR});
        axi_wr(`SEQ_ADDR_STATUS, 32'hFFFFFFFF, r);
        check({30'h0, r}, {30'h0, `SEQ_RESP_OKAY});
    endtask
    task automatic t_cleared;
        axi_rd(`SEQ_ADDR_STATUS, d, r);
        check(d, 32'h00003000);
        axi_rd(`SEQ_ADDR_REGS, d, r);
        check(d, 32'h0);
        check({24'h0, port_d_out}, 32'h0);
    endtask
    task automatic t_backup;
        // Stop first so that no instruction slot lands right beside the restart.
        axi_wr(`SEQ_ADDR_CTRL, 32'h0, r);
        axi_wr(`SEQ_ADDR_CTRL, 32'h2, r);
        t_cleared;
        axi_wr(`SEQ_ADDR_CTRL, 32'h1, r);
        repeat (16) @(posedge aclk);
        axi_wr(`SEQ_ADDR_CTRL, 32'h0, r);
        @(posedge aclk);
        backup_return <= 1'b1;
        @(posedge aclk);
        backup_return <= 1'b0;
        t_cleared;
    endtask
    initial begin
        // Fill with add-zero words so running off the program is harmless and the page roll stays visible.
        for (int i = 0; i < 2048; i++) rom.mem[i] = 9'h080;
        for (int i = 0; i < 24; i++) rom.mem[i] = prog[i];
        rom.mem[11'h07E] = 9'h00D;
        rom.mem[11'h07F] = 9'h050;
        rom.mem[11'h080] = 9'h00C;
        rom.mem[11'h081] = 9'h101;
        rom.mem[11'h100] = 9'h007;
        rom.mem[11'h2BB] = 9'h1A7;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_state;
        t_program;
        t_map;
        t_backup;
        close_out;
    end
    initial begin
        #100000;
        miscompares++;
        close_out;
    end
endmodule
`default_nettype wire
